/* File: verilog/hrp_pkg.sv */
package hrp_pkg;

   // ***********************************
   // host port locations
   // ***********************************
   localparam logic [2:0] ADDR_DEST = 3'h4;
   localparam logic [2:0] ADDR_READ_SEL = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h7;
   localparam logic [7:0] GAIN_CAPTURE_DEST = 8'h0a;

   // ***********************************
   // read codes
   // ***********************************
   localparam logic [2:0] CODE_IQ = 3'h0;
   localparam logic [2:0] CODE_MAG_PHASE = 3'h1;
   localparam logic [2:0] CODE_FREQ = 3'h2;
   localparam logic [2:0] CODE_LEVEL = 3'h4;
   localparam logic [2:0] CODE_GAIN_TE = 3'h5;

   // ***********************************
   // byte addresses within a source
   // ***********************************
   localparam logic [2:0] BYTE_A_LO = 3'h0;
   localparam logic [2:0] BYTE_A_HI = 3'h1;
   localparam logic [2:0] BYTE_B_LO = 3'h2;
   localparam logic [2:0] BYTE_B_HI = 3'h3;

   // ***********************************
   // status byte layout
   // ***********************************
   localparam int STAT_DEPTH_LSB = 4;
   localparam int STAT_EMPTY = 3;
   localparam int STAT_FULL = 2;
   localparam int STAT_THRESH_N = 1;
   localparam int STAT_LEVEL_DONE = 0;

   // ***********************************
   // reset values and unused byte
   // ***********************************
   localparam logic [2:0] RST_READ_CODE = 3'h0;
   localparam logic [14:0] RST_GAIN = 15'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] UNUSED_BYTE = 8'h00;

   typedef enum logic [1:0] {
      HRP_IDLE = 2'b00,
      HRP_DRIVE = 2'b01
   } hrp_state_e;

   // data sources on the sample clock
   typedef struct packed {
      logic [15:0] i_sample;
      logic [15:0] q_sample;
      logic [15:0] magnitude;
      logic [15:0] phase;
      logic [15:0] freq;
      logic [23:0] level;
      logic [10:0] gain_mantissa;
      logic [3:0] gain_shift;
      logic [15:0] timing_error;
   } hrp_src_s;

   // buffer and detector flags
   typedef struct packed {
      logic [2:0] fifo_depth;
      logic buf_empty;
      logic buf_full;
      logic buffer_threshold_flag_n;
      logic level_detect_done;
   } hrp_flags_s;

   // host pin group
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] data;
      logic wr_n;
      logic rd_n;
   } hrp_pins_s;

endpackage

/* File: verilog/hrp_readback.sv */
`timescale 1ns/1ps

module hrp_readback
   import hrp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire hrp_pins_s pins,
   input wire hrp_src_s src,
   input wire hrp_flags_s flags,
   input wire logic sample_valid,
   output logic [7:0] data_out,
   output logic data_oe_n,
   output logic buf_pop,
   output logic sample_wr_en
);

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      hrp_pins_s s1;
      hrp_pins_s s2;
      logic wr_s3;
      logic rd_s3;
      logic [2:0] read_code;
      logic [14:0] gain_hold;
      logic [7:0] data_out;
      logic pop;
      hrp_state_e fsm;
   } hrp_st_s;

   localparam hrp_st_s RST_ST = '{
      s1: '{addr: 3'h0, data: 8'h00, wr_n: 1'b1, rd_n: 1'b1},
      s2: '{addr: 3'h0, data: 8'h00, wr_n: 1'b1, rd_n: 1'b1},
      wr_s3: 1'b1,
      rd_s3: 1'b1,
      read_code: RST_READ_CODE,
      gain_hold: RST_GAIN,
      data_out: RST_BYTE,
      pop: 1'b0,
      fsm: HRP_IDLE
   };

   hrp_st_s st;
   hrp_st_s next_st;
   logic wr_rise;
   logic rd_fall;
   logic rd_rise;
   logic [6:0] status_bits;
   logic [7:0] sel_byte;
   logic last_byte;

   // ***********************************
   // strobe edges and status
   // ***********************************
   assign wr_rise = st.s2.wr_n && !st.wr_s3;
   assign rd_fall = !st.s2.rd_n && st.rd_s3;
   assign rd_rise = st.s2.rd_n && !st.rd_s3;

   assign status_bits = {flags.fifo_depth,
                         flags.buf_empty,
                         flags.buf_full,
                         flags.buffer_threshold_flag_n,
                         flags.level_detect_done};

   // ***********************************
   // byte select
   // ***********************************
   always_comb begin
      sel_byte = UNUSED_BYTE;
      last_byte = 1'b0;
      if (st.s2.addr == ADDR_STATUS) begin
         sel_byte = {1'b0, status_bits};
      end else begin
         case (st.read_code)
            CODE_IQ: begin
               case (st.s2.addr)
                  BYTE_A_LO: sel_byte = src.i_sample[7:0];
                  BYTE_A_HI: sel_byte = src.i_sample[15:8];
                  BYTE_B_LO: sel_byte = src.q_sample[7:0];
                  BYTE_B_HI: begin
                     sel_byte = src.q_sample[15:8];
                     last_byte = 1'b1;
                  end
                  default: sel_byte = UNUSED_BYTE;
               endcase
            end
            CODE_MAG_PHASE: begin
               case (st.s2.addr)
                  BYTE_A_LO: sel_byte = src.magnitude[7:0];
                  BYTE_A_HI: sel_byte = src.magnitude[15:8];
                  BYTE_B_LO: sel_byte = src.phase[7:0];
                  BYTE_B_HI: begin
                     sel_byte = src.phase[15:8];
                     last_byte = 1'b1;
                  end
                  default: sel_byte = UNUSED_BYTE;
               endcase
            end
            CODE_FREQ: begin
               case (st.s2.addr)
                  BYTE_A_LO: sel_byte = src.freq[7:0];
                  BYTE_A_HI: begin
                     sel_byte = src.freq[15:8];
                     last_byte = 1'b1;
                  end
                  default: sel_byte = UNUSED_BYTE;
               endcase
            end
            CODE_LEVEL: begin
               case (st.s2.addr)
                  BYTE_A_LO: sel_byte = src.level[7:0];
                  BYTE_A_HI: sel_byte = src.level[15:8];
                  BYTE_B_LO: sel_byte = src.level[23:16];
                  default: sel_byte = UNUSED_BYTE;
               endcase
            end
            CODE_GAIN_TE: begin
               case (st.s2.addr)
                  BYTE_A_LO: sel_byte = st.gain_hold[7:0];
                  BYTE_A_HI: sel_byte = {1'b0, st.gain_hold[14:8]};
                  BYTE_B_LO: sel_byte = src.timing_error[7:0];
                  BYTE_B_HI: sel_byte = src.timing_error[15:8];
                  default: sel_byte = UNUSED_BYTE;
               endcase
            end
            default: sel_byte = UNUSED_BYTE;
         endcase
      end
   end

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.wr_s3 = st.s2.wr_n;
      next_st.rd_s3 = st.s2.rd_n;
      next_st.pop = 1'b0;
      if (wr_rise) begin
         if (st.s2.addr == ADDR_READ_SEL) begin
            next_st.read_code = st.s2.data[2:0];
         end
         if (st.s2.addr == ADDR_DEST && st.s2.data == GAIN_CAPTURE_DEST) begin
            next_st.gain_hold = {src.gain_shift, src.gain_mantissa};
         end
      end
      case (st.fsm)
         HRP_IDLE: begin
            if (rd_fall) begin
               next_st.data_out = sel_byte;
               next_st.fsm = HRP_DRIVE;
               next_st.pop = last_byte && !flags.buf_empty;
            end
         end
         HRP_DRIVE: begin
            if (rd_rise || st.s2.rd_n) begin
               next_st.fsm = HRP_IDLE;
            end
         end
         default: next_st.fsm = HRP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= RST_ST;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   assign data_out = st.data_out;
   assign data_oe_n = (st.fsm != HRP_DRIVE);
   assign buf_pop = st.pop;
   assign sample_wr_en = sample_valid && !flags.buf_full;

   // ***********************************
   // checks
   // ***********************************
   property p_read_code_latch;
      @(posedge clk) disable iff (rst)
         (wr_rise && st.s2.addr == ADDR_READ_SEL) |=> (st.read_code == $past(st.s2.data[2:0]));
   endproperty
   a_read_code_latch: assert property (p_read_code_latch) else $error("read code not latched");

   property p_drive_on_fall;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE) |=> (!data_oe_n && data_out == $past(sel_byte));
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) else $error("byte not driven after read fall");

   property p_status_fast;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.s2.addr == ADDR_STATUS) |=> (data_out == {1'b0, $past(status_bits)});
   endproperty
   a_status_fast: assert property (p_status_fast) else $error("status byte wrong");

   property p_level_bytes;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_LEVEL && st.s2.addr == BYTE_B_LO)
         |=> (data_out == $past(src.level[23:16]));
   endproperty
   a_level_bytes: assert property (p_level_bytes) else $error("level top byte wrong");

   property p_gain_hold;
      @(posedge clk) disable iff (rst)
         !(wr_rise && st.s2.addr == ADDR_DEST) |=> $stable(st.gain_hold);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain changed without capture");

   property p_te_direct;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_GAIN_TE && st.s2.addr == BYTE_B_HI)
         |=> (data_out == $past(src.timing_error[15:8]));
   endproperty
   a_te_direct: assert property (p_te_direct) else $error("timing error byte wrong");

   property p_no_pop_empty;
      @(posedge clk) disable iff (rst)
         buf_pop |-> $past(!flags.buf_empty);
   endproperty
   a_no_pop_empty: assert property (p_no_pop_empty) else $error("pop while empty");

   property p_no_write_full;
      @(posedge clk) disable iff (rst)
         flags.buf_full |-> !sample_wr_en;
   endproperty
   a_no_write_full: assert property (p_no_write_full) else $error("write while full");

   property p_unused_zero;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == 3'h3 && st.s2.addr != ADDR_STATUS)
         |=> (data_out == UNUSED_BYTE);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused code not zero");

   property p_release;
      @(posedge clk) disable iff (rst)
         (st.s2.rd_n && st.rd_s3) |-> data_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("bus driven with read high");

   property p_read_code_hold;
      @(posedge clk) disable iff (rst)
         !(wr_rise && st.s2.addr == ADDR_READ_SEL) |=> $stable(st.read_code);
   endproperty
   a_read_code_hold: assert property (p_read_code_hold) else $error("read code changed without select write");

   property p_gain_capture;
      @(posedge clk) disable iff (rst)
         (wr_rise && st.s2.addr == ADDR_DEST && st.s2.data == GAIN_CAPTURE_DEST)
         |=> (st.gain_hold == $past({src.gain_shift, src.gain_mantissa}));
   endproperty
   a_gain_capture: assert property (p_gain_capture) else $error("gain not captured on location write");

   property p_iq_bytes;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_IQ && st.s2.addr == BYTE_B_LO)
         |=> (data_out == $past(src.q_sample[7:0]));
   endproperty
   a_iq_bytes: assert property (p_iq_bytes) else $error("q low byte wrong");

   property p_mag_bytes;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_MAG_PHASE && st.s2.addr == BYTE_A_HI)
         |=> (data_out == $past(src.magnitude[15:8]));
   endproperty
   a_mag_bytes: assert property (p_mag_bytes) else $error("magnitude high byte wrong");

   property p_freq_bytes;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_FREQ && st.s2.addr == BYTE_A_LO)
         |=> (data_out == $past(src.freq[7:0]));
   endproperty
   a_freq_bytes: assert property (p_freq_bytes) else $error("frequency low byte wrong");

   property p_level_low;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_LEVEL && st.s2.addr == BYTE_A_LO)
         |=> (data_out == $past(src.level[7:0]));
   endproperty
   a_level_low: assert property (p_level_low) else $error("level low byte wrong");

   property p_gain_low;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_GAIN_TE && st.s2.addr == BYTE_A_LO)
         |=> (data_out == $past(st.gain_hold[7:0]));
   endproperty
   a_gain_low: assert property (p_gain_low) else $error("gain low byte wrong");

   property p_gain_high;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_GAIN_TE && st.s2.addr == BYTE_A_HI)
         |=> (data_out == {1'b0, $past(st.gain_hold[14:8])});
   endproperty
   a_gain_high: assert property (p_gain_high) else $error("gain high byte wrong");

   property p_pop_last;
      @(posedge clk) disable iff (rst)
         (rd_fall && st.fsm == HRP_IDLE && st.read_code == CODE_IQ && st.s2.addr == BYTE_B_HI && !flags.buf_empty)
         |=> buf_pop;
   endproperty
   a_pop_last: assert property (p_pop_last) else $error("no pop after last byte of set");

   property p_pop_pulse;
      @(posedge clk) disable iff (rst)
         buf_pop |=> !buf_pop;
   endproperty
   a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than one cycle");

   property p_release_rise;
      @(posedge clk) disable iff (rst)
         rd_rise |=> data_oe_n;
   endproperty
   a_release_rise: assert property (p_release_rise) else $error("bus not released after read rise");

   property p_oe_hold;
      @(posedge clk) disable iff (rst)
         (!data_oe_n && !st.s2.rd_n) |=> (!data_oe_n && $stable(data_out));
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("byte not held while read low");

   property p_write_room;
      @(posedge clk) disable iff (rst)
         (sample_valid && !flags.buf_full) |-> sample_wr_en;
   endproperty
   a_write_room: assert property (p_write_room) else $error("sample dropped with room in buffer");

endmodule

/* File: tb/hrp_host_model.sv */
`timescale 1ns/1ps

// ***********************************
// host processor on the byte bus
// ***********************************
module hrp_host_model
   import hrp_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   output hrp_pins_s pins
);
   logic [2:0] a = 3'h0;
   logic [7:0] host_drive = 8'h00;
   logic wr_n = 1'b1;
   logic rd_n = 1'b1;

   // device wins the bus while it drives
   assign pins = {a, (data_oe_n ? host_drive : data_out), wr_n, rd_n};

   // location write, taken on the rising strobe
   task automatic wr(input logic [2:0] addr, input logic [7:0] d);
      @(negedge clk);
      a = addr;
      host_drive = d;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      wr_n = 1'b1;
      repeat (4) @(negedge clk);
      host_drive = ~d;
   endtask

   // one byte per strobe low period
   task automatic rd(input logic [2:0] addr, output logic [7:0] d, output logic on, output logic off);
      @(negedge clk);
      a = addr;
      rd_n = 1'b0;
      repeat (5) @(negedge clk);
      d = data_out;
      on = data_oe_n;
      rd_n = 1'b1;
      repeat (5) @(negedge clk);
      off = data_oe_n;
   endtask
endmodule

/* File: tb/hrp_readback_tb.sv */
`timescale 1ns/1ps

// ***********************************
// readback port bench
// ***********************************
module hrp_readback_tb
   import hrp_pkg::*;
;
   logic clk;
   logic rst = 1'b1;
   hrp_pins_s pins;
   hrp_src_s src = '0;
   hrp_flags_s flags = '{3'h0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic sample_valid = 1'b0;
   logic [7:0] data_out;
   logic data_oe_n;
   logic buf_pop;
   logic sample_wr_en;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_pop = 0;

   hrp_readback DUT (.clk(clk), .rst(rst), .pins(pins), .src(src), .flags(flags),
      .sample_valid(sample_valid), .data_out(data_out), .data_oe_n(data_oe_n),
      .buf_pop(buf_pop), .sample_wr_en(sample_wr_en));
   hrp_host_model host (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (buf_pop === 1'b1)
         n_pop++;
      if (cycles == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // ***********************************
   // checking helpers
   // ***********************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic on;
      logic off;
      host.rd(a, d, on, off);
      check(what, d, exp);
      check("oe while reading", {7'h0, on}, 8'h00);
      check("oe after read", {7'h0, off}, 8'h01);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_level();
      src.level = 24'h321af5;
      host.wr(ADDR_READ_SEL, 8'hfc);
      rd_chk("level lo", 3'h0, 8'hf5);
      rd_chk("level mid", 3'h1, 8'h1a);
      rd_chk("level hi", 3'h2, 8'h32);
      rd_chk("level none", 3'h3, UNUSED_BYTE);
   endtask

   task automatic t_samples();
      logic [7:0] e [0:2][0:3] = '{'{8'h34, 8'h12, 8'h78, 8'h56}, '{8'hbc, 8'h9a, 8'hf0, 8'hde},
         '{8'hf1, 8'h0f, 8'h00, 8'h00}};
      int p0;
      src.i_sample = 16'h1234;
      src.q_sample = 16'h5678;
      src.magnitude = 16'h9abc;
      src.phase = 16'hdef0;
      src.freq = 16'h0ff1;
      flags.buf_empty = 1'b0;
      for (int c = 0; c < 3; c++) begin
         host.wr(ADDR_READ_SEL, 8'(c));
         p0 = n_pop;
         for (int a = 0; a < 4; a++) begin
            rd_chk("sample byte", 3'(a), e[c][a]);
         end
         check("pops per set", 8'(n_pop - p0), 8'h01);
      end
      flags.buf_empty = 1'b1;
      host.wr(ADDR_READ_SEL, 8'h00);
      p0 = n_pop;
      rd_chk("q hi empty", 3'h3, 8'h56);
      check("pop when empty", 8'(n_pop - p0), 8'h00);
   endtask

   task automatic t_gain();
      src.gain_mantissa = 11'h5a3;
      src.gain_shift = 4'h9;
      src.timing_error = 16'hbeef;
      host.wr(ADDR_DEST, GAIN_CAPTURE_DEST);
      src.gain_mantissa = 11'h000;
      src.gain_shift = 4'h0;
      host.wr(ADDR_READ_SEL, 8'h05);
      rd_chk("gain lo", 3'h0, 8'ha3);
      rd_chk("gain hi", 3'h1, 8'h4d);
      rd_chk("te lo", 3'h2, 8'hef);
      rd_chk("te hi", 3'h3, 8'hbe);
      rd_chk("gain none", 3'h4, UNUSED_BYTE);
   endtask

   task automatic t_status();
      flags = '{3'h5, 1'b1, 1'b0, 1'b1, 1'b0};
      rd_chk("status a", ADDR_STATUS, 8'h5a);
      flags = '{3'h2, 1'b0, 1'b1, 1'b0, 1'b1};
      rd_chk("status b", ADDR_STATUS, 8'h25);
      for (int c = 3; c < 8; c++) begin
         if (c == 4 || c == 5)
            continue;
         host.wr(ADDR_READ_SEL, 8'(c));
         rd_chk("unused code", 3'h0, UNUSED_BYTE);
      end
   endtask

   task automatic t_wr_en();
      @(negedge clk);
      sample_valid = 1'b1;
      #1;
      check("write when full", {7'h0, sample_wr_en}, 8'h00);
      @(negedge clk);
      flags.buf_full = 1'b0;
      #1;
      check("write when room", {7'h0, sample_wr_en}, 8'h01);
      @(negedge clk);
      sample_valid = 1'b0;
   endtask

   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      check("oe after reset", {7'h0, data_oe_n}, 8'h01);
      check("pop after reset", {7'h0, buf_pop}, 8'h00);
      t_level();
      t_samples();
      t_gain();
      t_status();
      t_wr_en();
      report_and_stop();
   end
endmodule
